// ### bench/decu_chk.sv
`timescale 1ns/10ps
module decu_chk
  import decu_pkg::*;
(
  // request side
  input wire logic i_clock,
  input wire logic i_resetn,
  input wire decu_req_s i_req,
  input wire logic [1:0] i_cpl,
  input wire logic i_ucnt_rd,
  input wire logic i_user_count_read_enable,
  // answers
  input wire logic o_rvalid,
  input wire logic o_fault,
  input wire logic o_ucnt_valid,
  input wire logic o_ucnt_fault,
  input wire logic [7:0] o_evt_code_0,
  input wire logic [7:0] o_umask_0,
  input wire logic [1:0] o_monitor_pins,
  input wire logic o_irq
);
  default clocking @(posedge i_clock);
  endclocking
  default disable iff (!i_resetn);
  // ----------------------------------------
  // shadow of lane 0 pin mode
  // ----------------------------------------
  logic pin_ovf;
  logic next_pin_ovf;
  logic kwr;
  logic kacc;
  assign kwr = i_req.wr && i_cpl == DECU_CPL_KERNEL;
  assign kacc = (i_req.rd || i_req.wr) && i_cpl == DECU_CPL_KERNEL;
  // refused writes never reach the control register
  always_comb begin
    next_pin_ovf = pin_ovf;
    if (kwr && i_req.idx == DECU_IDX_SEL0) begin
      next_pin_ovf = !i_req.wdata[DECU_PIN_BIT];
    end
  end
  always_ff @(posedge i_clock) begin
    if (!i_resetn) begin
      pin_ovf <= 1'b1;
    end else begin
      pin_ovf <= next_pin_ovf;
    end
  end
  // ----------------------------------------
  // properties
  // ----------------------------------------
  sequence s_sel0_wr;
    kwr && i_req.idx == DECU_IDX_SEL0 ##1 !i_req.wr;
  endsequence
  chk_read_answer: assert property (
    i_req.rd && kacc |=> o_rvalid && !o_fault)
    else $error("kernel read not answered");
  chk_fault_refuse: assert property (
    (i_req.rd || i_req.wr) && !kacc |=> o_fault && !o_rvalid)
    else $error("user access not refused");
  chk_idle_quiet: assert property (
    !i_req.rd && !i_req.wr |=> !o_rvalid && !o_fault)
    else $error("answer without request");
  chk_ucnt_refuse: assert property (
    i_ucnt_rd && i_cpl != DECU_CPL_KERNEL && !i_user_count_read_enable
    |=> o_ucnt_fault && !o_ucnt_valid)
    else $error("user count read not refused");
  chk_ucnt_grant: assert property (
    i_ucnt_rd && (i_cpl == DECU_CPL_KERNEL || i_user_count_read_enable)
    |=> o_ucnt_valid && !o_ucnt_fault)
    else $error("user count read not granted");
  chk_code_follow: assert property (
    s_sel0_wr |=> o_evt_code_0 == $past(i_req.wdata[7:0], 2) &&
    o_umask_0 == $past(i_req.wdata[15:8], 2))
    else $error("event code or mask mismatch");
  chk_pin_single: assert property (
    pin_ovf && o_monitor_pins[0] |=> !o_monitor_pins[0])
    else $error("overflow pin pulse too long");
  chk_irq_single: assert property (o_irq |=> !o_irq)
    else $error("interrupt pulse too long");
  chk_reset_quiet: assert property (
    $rose(i_resetn) |-> o_monitor_pins == 2'h0 && !o_irq && !o_rvalid)
    else $error("outputs busy after reset");
endmodule

bind decu_top decu_chk u_chk (
  .i_clock(i_clock), .i_resetn(i_resetn), .i_req(i_req), .i_cpl(i_cpl),
  .i_ucnt_rd(i_ucnt_rd),
  .i_user_count_read_enable(i_user_count_read_enable),
  .o_rvalid(o_rvalid), .o_fault(o_fault), .o_ucnt_valid(o_ucnt_valid),
  .o_ucnt_fault(o_ucnt_fault), .o_evt_code_0(o_evt_code_0),
  .o_umask_0(o_umask_0), .o_monitor_pins(o_monitor_pins), .o_irq(o_irq)
);

// ### bench/decu_top_tb.sv
`timescale 1ns/10ps
module decu_top_tb
  import decu_pkg::*;
;
  logic i_clock = 1'b0;
  logic i_resetn = 1'b0;
  decu_req_s i_req = '0;
  logic [1:0] i_cpl = 2'h0;
  logic i_ucnt_rd = 1'b0;
  logic i_ucnt_sel = 1'b0;
  logic i_user_count_read_enable = 1'b0;
  logic [7:0] i_evt_num = 8'h00;
  logic [31:0] o_rdata;
  logic [39:0] o_rdata_wide, o_ucnt_data;
  logic o_rvalid, o_fault, o_ucnt_valid, o_ucnt_fault, o_irq;
  logic [7:0] o_evt_code_0, o_evt_code_1, o_umask_0, o_umask_1;
  logic [1:0] o_monitor_pins;
  int fail_count = 0;
  int n_checks = 0;
  int pin_hits = 0;
  int irq_hits = 0;
  decu_top dut (
    .i_clock(i_clock), .i_resetn(i_resetn), .i_req(i_req), .i_cpl(i_cpl),
    .o_rdata(o_rdata), .o_rdata_wide(o_rdata_wide), .o_rvalid(o_rvalid),
    .o_fault(o_fault), .i_ucnt_rd(i_ucnt_rd), .i_ucnt_sel(i_ucnt_sel),
    .i_user_count_read_enable(i_user_count_read_enable),
    .o_ucnt_data(o_ucnt_data), .o_ucnt_valid(o_ucnt_valid),
    .o_ucnt_fault(o_ucnt_fault), .i_evt_num(i_evt_num),
    .o_evt_code_0(o_evt_code_0), .o_evt_code_1(o_evt_code_1),
    .o_umask_0(o_umask_0), .o_umask_1(o_umask_1),
    .o_monitor_pins(o_monitor_pins), .o_irq(o_irq)
  );
  // clock, and a tally of pulses so their length shows in the count
  always #20 i_clock = ~i_clock;
  always @(posedge i_clock) begin
    pin_hits += o_monitor_pins[0];
    irq_hits += o_irq;
  end
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic cmp(input logic [39:0] got, input logic [39:0] exp);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one-cycle request, answer sampled just after the edge that ends it
  task automatic acc(input logic rd, wr, input logic [1:0] idx,
      input logic [31:0] d);
    @(posedge i_clock);
    i_req <= '{rd: rd, wr: wr, idx: idx, wdata: d};
    @(posedge i_clock);
    i_req <= '0;
    #1;
  endtask
  task automatic evt(input logic [3:0] n);
    @(posedge i_clock);
    i_evt_num <= {n, n};
  endtask
  task automatic ur(input logic [1:0] cpl, input logic en,
      input logic [1:0] fv, input logic [39:0] d);
    @(posedge i_clock);
    i_cpl <= cpl;
    i_user_count_read_enable <= en;
    i_ucnt_rd <= 1'b1;
    @(posedge i_clock);
    i_ucnt_rd <= 1'b0;
    i_cpl <= 2'h0;
    #1;
    cmp({38'h0, o_ucnt_fault, o_ucnt_valid}, {38'h0, fv});
    if (fv[0]) cmp(o_ucnt_data, d);
  endtask
  // preset, configure, feed four cycles of events, stop, read back
  task automatic run(input logic ov, l1, input logic [31:0] s0,
      input logic [1:0] cpl, input logic [15:0] nums,
      input logic [7:0] e0, input logic [1:0] pi);
    logic [31:0] pre;
    logic [15:0] f1;
    int p0;
    int q0;
    pre = ov ? 32'hFFFFFFFF : 32'h0;
    f1 = l1 ? s0[15:0] : 16'h0;
    p0 = pin_hits;
    q0 = irq_hits;
    acc(1'b0, 1'b1, DECU_IDX_CNT0, pre);
    acc(1'b0, 1'b1, DECU_IDX_CNT1, pre);
    acc(1'b0, 1'b1, DECU_IDX_SEL1, l1 ? (s0 & 32'hFFBFFFFF) : 32'h0);
    acc(1'b0, 1'b1, DECU_IDX_SEL0, s0);
    @(posedge i_clock);
    i_cpl <= cpl;
    for (int k = 0; k < 4; k++) evt(nums[4*k +: 4]);
    evt(4'h0);
    i_cpl <= 2'h0;
    repeat (6) @(posedge i_clock);
    #1;
    cmp({24'h0, o_umask_0, o_evt_code_0}, {24'h0, s0[15:0]});
    cmp({24'h0, o_umask_1, o_evt_code_1}, {24'h0, f1});
    cmp(40'(pin_hits - p0), {39'h0, pi[1]});
    cmp(40'(irq_hits - q0), {39'h0, pi[0]});
    acc(1'b0, 1'b1, DECU_IDX_SEL0, 32'h0);
    evt(4'h5);
    evt(4'h0);
    acc(1'b1, 1'b0, DECU_IDX_CNT0, 32'h0);
    cmp(o_rdata_wide, {32'h0, e0});
    acc(1'b1, 1'b0, DECU_IDX_CNT1, 32'h0);
    cmp(o_rdata_wide, l1 ? {32'h0, e0} : {{8{pre[31]}}, pre});
  endtask
  // ----------------------------------------
  // watchdog and main sequence
  // ----------------------------------------
  initial begin
    #200000;
    fail_count++;
    print_verdict();
  end
  initial begin
    repeat (16) @(posedge i_clock);
    i_resetn <= 1'b1;
    acc(1'b1, 1'b0, DECU_IDX_SEL0, 32'h0);
    cmp({8'h00, o_rdata}, {8'h00, DECU_SEL_RESET});
    acc(1'b1, 1'b0, DECU_IDX_SEL1, 32'h0);
    cmp({8'h00, o_rdata}, {8'h00, DECU_SEL_RESET});
    acc(1'b0, 1'b1, DECU_IDX_CNT0, 32'h80000005);
    acc(1'b1, 1'b0, DECU_IDX_CNT0, 32'h0);
    cmp(o_rdata_wide, 40'hFF80000005);
    cmp({8'h00, o_rdata}, 40'h0080000005);
    acc(1'b0, 1'b1, DECU_IDX_CNT1, 32'h7FFFFFFF);
    acc(1'b1, 1'b0, DECU_IDX_CNT1, 32'h0);
    cmp(o_rdata_wide, 40'h007FFFFFFF);
    ur(2'h3, 1'b0, 2'h2, 40'h0);
    ur(2'h3, 1'b1, 2'h1, 40'hFF80000005);
    ur(2'h0, 1'b0, 2'h1, 40'hFF80000005);
    @(posedge i_clock);
    i_cpl <= 2'h3;
    acc(1'b0, 1'b1, DECU_IDX_SEL0, 32'h00430000);
    cmp({39'h0, o_fault}, 40'h1);
    @(posedge i_clock);
    i_cpl <= 2'h0;
    acc(1'b1, 1'b0, DECU_IDX_SEL0, 32'h0);
    cmp({8'h00, o_rdata}, 40'h0);
    acc(1'b0, 1'b1, DECU_IDX_SEL1, 32'hFFFFFFFF);
    acc(1'b1, 1'b0, DECU_IDX_SEL1, 32'h0);
    cmp({8'h00, o_rdata}, 40'hFFBFFFFF);
    run(1'b0, 1'b1, 32'h0042123C, 2'h0, 16'h3333, 8'h0C, 2'h0);
    run(1'b0, 1'b1, 32'h00410000, 2'h3, 16'h1111, 8'h04, 2'h0);
    run(1'b0, 1'b0, 32'h00410000, 2'h0, 16'h1111, 8'h00, 2'h0);
    run(1'b0, 1'b0, 32'h00420000, 2'h2, 16'h1111, 8'h00, 2'h0);
    run(1'b0, 1'b0, 32'h00430000, 2'h1, 16'h2121, 8'h06, 2'h0);
    run(1'b0, 1'b0, 32'h02420000, 2'h0, 16'h3321, 8'h03, 2'h0);
    // inverted: idle cycles while enabled are below threshold and count too
    run(1'b0, 1'b0, 32'h02C20000, 2'h0, 16'h3321, 8'h0B, 2'h0);
    run(1'b0, 1'b0, 32'h01420000, 2'h0, 16'h3201, 8'h03, 2'h0);
    run(1'b0, 1'b0, 32'h01460000, 2'h0, 16'h1011, 8'h02, 2'h0);
    run(1'b0, 1'b0, 32'h004A0000, 2'h0, 16'h0002, 8'h02, 2'h2);
    run(1'b1, 1'b0, 32'h00520000, 2'h0, 16'h0001, 8'h00, 2'h3);
    run(1'b0, 1'b1, 32'h00020000, 2'h0, 16'h1111, 8'h00, 2'h0);
    print_verdict();
  end
endmodule

// ### core/decu_lane.sv
`timescale 1ns/10ps
// one counting lane: qualification, edge, threshold, increment amount
module decu_lane
  import decu_pkg::*;
#(
  parameter int EVN_W = DECU_EVN_W
) (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_resetn,
  // control
  input wire decu_sel_s i_sel,
  input wire logic i_run,
  input wire logic [1:0] i_cpl,
  // events this cycle for the selected code
  input wire logic [EVN_W-1:0] i_evt_num,
  // outputs
  output logic [EVN_W-1:0] o_add
);
  initial begin
    if (EVN_W < 1 || EVN_W > 8) $error("decu_lane: EVN_W out of range");
  end

  logic prev_cond;
  logic next_prev_cond;
  logic priv_ok;
  logic ge;
  logic cond;

  // privilege qualification and threshold compare
  always_comb begin
    priv_ok = (i_cpl == DECU_CPL_KERNEL) ? i_sel.krn
                                         : i_sel.user_level_qualifier;
    // widen the event count to the threshold field on purpose
    ge = (8'(i_evt_num) >= i_sel.thresh);
    cond = priv_ok && i_run && ((i_sel.thresh != 8'h00)
           ? (ge ^ i_sel.invert)
           : (i_evt_num != '0));
    next_prev_cond = cond;
    if (i_sel.edge_det) begin
      // rising edge only; back-to-back assertions merge into one
      o_add = (cond && !prev_cond) ? EVN_W'(1) : '0;
    end else if (!cond) begin
      o_add = '0;
    end else if (i_sel.thresh != 8'h00) begin
      o_add = EVN_W'(1);
    end else begin
      o_add = i_evt_num;
    end
  end

  // previous condition for edge detect
  always_ff @(posedge i_clock) begin
    if (!i_resetn) begin
      prev_cond <= 1'b0;
    end else begin
      prev_cond <= next_prev_cond;
    end
  end
endmodule

// ### core/decu_pkg.sv
package decu_pkg;
  // register indices on the model-specific register access path
  localparam logic [1:0] DECU_IDX_SEL0 = 2'h0;
  localparam logic [1:0] DECU_IDX_SEL1 = 2'h1;
  localparam logic [1:0] DECU_IDX_CNT0 = 2'h2;
  localparam logic [1:0] DECU_IDX_CNT1 = 2'h3;
  // control field positions
  localparam int DECU_EVT_LSB = 0;
  localparam int DECU_UMASK_LSB = 8;
  localparam int DECU_USR_BIT = 16;
  localparam int DECU_KRN_BIT = 17;
  localparam int DECU_EDGE_BIT = 18;
  localparam int DECU_PIN_BIT = 19;
  localparam int DECU_INT_BIT = 20;
  localparam int DECU_EN_BIT = 22;
  localparam int DECU_INV_BIT = 23;
  localparam int DECU_THR_LSB = 24;
  localparam int DECU_SIGN_BIT = 31;
  // sizes and reset values
  localparam int DECU_CNT_W = 40;
  localparam int DECU_EVN_W = 4;
  localparam logic [31:0] DECU_SEL_RESET = 32'h0000_0000;
  localparam logic [1:0] DECU_CPL_KERNEL = 2'h0;
  // control register view
  typedef struct packed {
    logic [7:0] thresh;
    logic invert;
    logic global_en;
    logic rsvd;
    logic int_en;
    logic pin_sel;
    logic edge_det;
    logic krn;
    logic user_level_qualifier;
    logic [7:0] umask;
    logic [7:0] evt;
  } decu_sel_s;
  // register access request
  typedef struct packed {
    logic rd;
    logic wr;
    logic [1:0] idx;
    logic [31:0] wdata;
  } decu_req_s;
endpackage

// ### core/decu_top.sv
`timescale 1ns/10ps
// Function
// - low eight control bits select the event code
// - bits 8..15 form the unit mask qualifying the event
// - user qualifier bit 16 counts at privilege levels 1 to 3
// - kernel qualifier bit 17 counts at privilege level 0
// - edge bit 18 counts only rising transitions of the condition
// - pin bit 19: pulse on every increment, else only on overflow
// - a monitor pin stays high one bus clock for each cycle with an increment or overflow
// - interrupt bit 20 requests interrupt on counter overflow
// - global enable bit 22 in first control runs both counters
// - invert bit 23 inverts the threshold comparison
// - nonzero threshold adds one when events reach the threshold
// - zero threshold adds the number of events each cycle
// - user counter reads need the read-enable flag or level 0
// - counter writes keep low 32 bits and sign-extend bit 31
// - register path reads and writes only at privilege level 0
// - counting starts right after the write setting global enable
// - clearing enable or both controls stops; clearing second stops it
// - two independent 40-bit counters
// - duration selections add one per clock while condition holds
module decu_top
  import decu_pkg::*;
#(
  parameter int CNT_W = DECU_CNT_W,
  parameter int EVN_W = DECU_EVN_W
) (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_resetn,
  // model register access path
  input wire decu_req_s i_req,
  input wire logic [1:0] i_cpl,
  output logic [31:0] o_rdata,
  output logic [CNT_W-1:0] o_rdata_wide,
  output logic o_rvalid,
  output logic o_fault,
  // user counter read instruction
  input wire logic i_ucnt_rd,
  input wire logic i_ucnt_sel,
  input wire logic i_user_count_read_enable,
  output logic [CNT_W-1:0] o_ucnt_data,
  output logic o_ucnt_valid,
  output logic o_ucnt_fault,
  // event sources: count per lane, chosen outside by event code
  input wire logic [2*EVN_W-1:0] i_evt_num,
  output logic [7:0] o_evt_code_0,
  output logic [7:0] o_evt_code_1,
  output logic [7:0] o_umask_0,
  output logic [7:0] o_umask_1,
  // monitor pins and interrupt request
  output logic [1:0] o_monitor_pins,
  output logic o_irq
);
  initial begin
    if (CNT_W != DECU_CNT_W) $error("decu_top: counter must be 40 bits");
    if (EVN_W < 1 || EVN_W > 8) $error("decu_top: EVN_W out of range");
  end

  // ------------------------------------------------------------
  // register state
  // ------------------------------------------------------------
  decu_sel_s sel [2];
  decu_sel_s next_sel [2];
  logic [CNT_W-1:0] cnt [2];
  logic [CNT_W-1:0] next_cnt [2];
  logic [1:0] ovf;
  logic [1:0] next_ovf;
  logic [1:0] incr;
  logic [1:0] next_incr;
  logic [EVN_W-1:0] add [2];
  logic [1:0] run;
  logic priv0;

  // sign-extend a written word to counter width
  function automatic logic [CNT_W-1:0] sext(input logic [31:0] w);
    sext = {{(CNT_W-32){w[DECU_SIGN_BIT]}}, w};
  endfunction

  // a write to this index from level 0 in this cycle
  function automatic logic wr_hit(input decu_req_s r, input logic p,
                                  input logic [1:0] idx);
    wr_hit = r.wr && p && (r.idx == idx);
  endfunction

  assign priv0 = (i_cpl == DECU_CPL_KERNEL);

  // global enable lives only in the first control register
  always_comb begin
    run[0] = sel[0].global_en && (sel[0] != '0);
    run[1] = sel[0].global_en && (sel[1] != '0);
  end

  // ------------------------------------------------------------
  // counting lanes
  // ------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_lane
      decu_lane #(.EVN_W(EVN_W)) u_lane (
        .i_clock(i_clock),
        .i_resetn(i_resetn),
        .i_sel(sel[g]),
        .i_run(run[g]),
        .i_cpl(i_cpl),
        .i_evt_num(i_evt_num[g*EVN_W +: EVN_W]),
        .o_add(add[g])
      );
    end
  endgenerate

  // next counter, control and event flags
  always_comb begin
    logic [CNT_W:0] sum;
    sum = '0;
    for (int i = 0; i < 2; i++) begin
      next_sel[i] = sel[i];
      next_cnt[i] = cnt[i];
      next_ovf[i] = 1'b0;
      next_incr[i] = 1'b0;
      // count then wrap; software write wins over the count
      sum = {1'b0, cnt[i]} + (CNT_W+1)'(add[i]);
      if (add[i] != '0) begin
        next_cnt[i] = sum[CNT_W-1:0];
        next_ovf[i] = sum[CNT_W];
        next_incr[i] = 1'b1;
      end
      if (wr_hit(i_req, priv0, i == 0 ? DECU_IDX_SEL0 : DECU_IDX_SEL1)) begin
        // new setup takes effect from the next cycle on
        next_sel[i] = decu_sel_s'(i_req.wdata);
        if (i == 1) begin
          next_sel[i].global_en = 1'b0;
        end
      end
      if (wr_hit(i_req, priv0, i == 0 ? DECU_IDX_CNT0 : DECU_IDX_CNT1)) begin
        next_cnt[i] = sext(i_req.wdata);
      end
    end
  end

  // pin pulses and interrupt request from one-cycle flags
  logic [1:0] next_pins;
  logic next_irq;
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      next_pins[i] = sel[i].pin_sel ? incr[i] : ovf[i];
    end
    next_irq = (ovf[0] && sel[0].int_en) ||
               (ovf[1] && sel[1].int_en);
  end

  // ------------------------------------------------------------
  // read paths
  // ------------------------------------------------------------
  logic [31:0] next_rdata;
  logic [CNT_W-1:0] next_rdata_wide;
  logic next_rvalid;
  logic next_fault;
  logic [CNT_W-1:0] next_ucnt;
  logic next_uvalid;
  logic next_ufault;
  always_comb begin
    next_rdata = 32'h0000_0000;
    next_rdata_wide = '0;
    next_rvalid = 1'b0;
    next_fault = (i_req.rd || i_req.wr) && !priv0;
    if (i_req.rd && priv0) begin
      next_rvalid = 1'b1;
      case (i_req.idx)
        DECU_IDX_SEL0: next_rdata = sel[0];
        DECU_IDX_SEL1: next_rdata = sel[1];
        DECU_IDX_CNT0: next_rdata_wide = cnt[0];
        DECU_IDX_CNT1: next_rdata_wide = cnt[1];
        default: next_rdata = 32'h0000_0000;
      endcase
      next_rdata = (i_req.idx[1]) ? next_rdata_wide[31:0] : next_rdata;
    end
    // user read allowed from any level while enabled
    next_ucnt = '0;
    next_uvalid = 1'b0;
    next_ufault = 1'b0;
    if (i_ucnt_rd) begin
      if (priv0 || i_user_count_read_enable) begin
        next_uvalid = 1'b1;
        next_ucnt = cnt[i_ucnt_sel];
      end else begin
        next_ufault = 1'b1;
      end
    end
  end

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  always_ff @(posedge i_clock) begin
    if (!i_resetn) begin
      sel[0] <= decu_sel_s'(DECU_SEL_RESET);
      sel[1] <= decu_sel_s'(DECU_SEL_RESET);
      cnt[0] <= '0;
      cnt[1] <= '0;
      ovf <= 2'h0;
      incr <= 2'h0;
      o_monitor_pins <= 2'h0;
      o_irq <= 1'b0;
      o_rdata <= 32'h0000_0000;
      o_rdata_wide <= '0;
      o_rvalid <= 1'b0;
      o_fault <= 1'b0;
      o_ucnt_data <= '0;
      o_ucnt_valid <= 1'b0;
      o_ucnt_fault <= 1'b0;
      o_evt_code_0 <= 8'h00;
      o_evt_code_1 <= 8'h00;
      o_umask_0 <= 8'h00;
      o_umask_1 <= 8'h00;
    end else begin
      sel[0] <= next_sel[0];
      sel[1] <= next_sel[1];
      cnt[0] <= next_cnt[0];
      cnt[1] <= next_cnt[1];
      ovf <= next_ovf;
      incr <= next_incr;
      o_monitor_pins <= next_pins;
      o_irq <= next_irq;
      o_rdata <= next_rdata;
      o_rdata_wide <= next_rdata_wide;
      o_rvalid <= next_rvalid;
      o_fault <= next_fault;
      o_ucnt_data <= next_ucnt;
      o_ucnt_valid <= next_uvalid;
      o_ucnt_fault <= next_ufault;
      o_evt_code_0 <= next_sel[0].evt;
      o_evt_code_1 <= next_sel[1].evt;
      o_umask_0 <= next_sel[0].umask;
      o_umask_1 <= next_sel[1].umask;
    end
  end
endmodule
